// File: txl_xlate_top.sv
// transmit translation table: indirect select/data register pair over APB
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module txl_xlate_top #(
  parameter int NUM_PORTS  = 32,
  parameter int NUM_GROUPS = 16
) (
  input  wire logic                       clk_in,
  input  wire logic                       sys_rst_in,
  input  wire logic                       psel_in,
  input  wire logic                       penable_in,
  input  wire logic                       pwrite_in,
  input  wire logic [txl_pkg::ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]                pwdata_in,
  output logic      [31:0]                prdata_out,
  output logic                            pready_out,
  output logic                            pslverr_out
);
  import txl_pkg::*;

  // ------------------------------------------------------------------
  // build check: only the three product sizes are served
  // ------------------------------------------------------------------
  if (!((NUM_PORTS == 2  && NUM_GROUPS == 2) ||
        (NUM_PORTS == 4  && NUM_GROUPS == 4) ||
        (NUM_PORTS == 32 && NUM_GROUPS == 16))) begin : g_bad
    $error("unsupported port and group count");
  end

  localparam logic [6:0] PORT_LIM  = 7'(NUM_PORTS);
  localparam logic [6:0] GROUP_LIM = 7'(GROUP_BASE) + 7'(NUM_GROUPS);

  txl_reg_if rif ();

  // ------------------------------------------------------------------
  // bus front end
  // ------------------------------------------------------------------
  txl_apb_fe u_fe (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .paddr_in    (paddr_in),
    .pwdata_in   (pwdata_in),
    .prdata_out  (prdata_out),
    .pready_out  (pready_out),
    .pslverr_out (pslverr_out),
    .rif         (rif)
  );

  logic [7:0]        sel_r;
  logic              reject_r;
  logic [CHAN_W-1:0] atm_rd;
  logic [CHAN_W-1:0] chan_rd;

  // ------------------------------------------------------------------
  // selection decode
  // ------------------------------------------------------------------
  wire              dir_rev  = sel_r[DIR_BIT];
  wire [ATM_W-1:0]  atm_idx  = sel_r[ATM_W-1:0];
  wire [CHAN_W-1:0] chan_idx = sel_r[CHAN_W-1:0];
  // a channel exists only if this build has that port or group
  wire chan_ok = ({1'b0, chan_idx} < PORT_LIM) ||
                 (({1'b0, chan_idx} >= 7'(GROUP_BASE)) &&
                  ({1'b0, chan_idx} < GROUP_LIM));
  wire sel_ok  = dir_rev ? chan_ok : 1'b1;

  // ------------------------------------------------------------------
  // data write checks: the code written for an ATM address
  // ------------------------------------------------------------------
  wire [CHAN_W-1:0] code_in = rif.wdata[CHAN_W-1:0];
  wire code_ok = ({1'b0, code_in} < PORT_LIM) ||
                 (({1'b0, code_in} >= 7'(GROUP_BASE)) &&
                  ({1'b0, code_in} < GROUP_LIM)) ||
                 (code_in == CODE_UNUSED);
  wire data_wr = rif.wr_en && (rif.reg_id == REG_DATA);
  wire atm_we  = data_wr && !dir_rev && code_ok;
  wire chan_we = data_wr && dir_rev && chan_ok;
  wire [CHAN_W-1:0] chan_wd = {rif.wdata[ACTIVE_BIT],
                               rif.wdata[ATM_W-1:0]};

  // selection register write steers both tables
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sel_r <= SEL_RST;
    end else if (rif.wr_en && rif.reg_id == REG_SEL) begin
      sel_r <= rif.wdata;
    end
  end

  // refused data writes are reported rather than silently dropped
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reject_r <= 1'b0;
    end else if (data_wr) begin
      reject_r <= !(atm_we || chan_we);
    end
  end

  // ------------------------------------------------------------------
  // the two direction tables; unset addresses start as not-this-device
  // ------------------------------------------------------------------
  txl_table_mem #(
    .W       (CHAN_W),
    .DEPTH   (ATM_DEPTH),
    .AW      (ATM_W),
    .RST_VAL (ATM_RST)
  ) u_atm_tab (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .wr_en_in    (atm_we),
    .wr_addr_in  (atm_idx),
    .wr_data_in  (code_in),
    .rd_addr_in  (atm_idx),
    .rd_data_out (atm_rd)
  );

  txl_table_mem #(
    .W       (CHAN_W),
    .DEPTH   (CHAN_DEPTH),
    .AW      (CHAN_W),
    .RST_VAL (CHAN_RST)
  ) u_chan_tab (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .wr_en_in    (chan_we),
    .wr_addr_in  (chan_idx),
    .wr_data_in  (chan_wd),
    .rd_addr_in  (chan_idx),
    .rd_data_out (chan_rd)
  );

  // ------------------------------------------------------------------
  // read mux; ignored bits and absent channels read zero
  // ------------------------------------------------------------------
  wire [7:0] atm_view  = {2'b00, atm_rd};
  wire [7:0] chan_view = chan_ok ?
                         {chan_rd[ATM_W], 2'b00, chan_rd[ATM_W-1:0]} :
                         8'h00;
  wire [7:0] data_view = dir_rev ? chan_view : atm_view;
  wire [7:0] stat_view = {6'h00, reject_r, sel_ok};

  assign rif.rdata = (rif.reg_id == REG_SEL)  ? sel_r     :
                     (rif.reg_id == REG_DATA) ? data_view :
                     (rif.reg_id == REG_STAT) ? stat_view : 8'h00;

endmodule
`default_nettype wire

// File: txl_pkg.sv
// package: constants of the transmit translation table register block
`default_nettype none
package txl_pkg;

  // ------------------------------------------------------------------
  // register indices and byte addresses (index times four)
  // ------------------------------------------------------------------
  localparam logic [11:0] SEL_IDX  = 12'h41b;
  localparam logic [11:0] DATA_IDX = 12'h41c;
  localparam logic [11:0] STAT_IDX = 12'h41d;
  localparam int          ADDR_W   = 16;
  localparam logic [15:0] SEL_ADDR  = {2'h0, SEL_IDX, 2'h0};
  localparam logic [15:0] DATA_ADDR = {2'h0, DATA_IDX, 2'h0};
  localparam logic [15:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};

  // ------------------------------------------------------------------
  // field positions, codes and reset values
  // ------------------------------------------------------------------
  localparam int          DIR_BIT     = 7;
  localparam int          ACTIVE_BIT  = 7;
  localparam int          CHAN_W      = 6;
  localparam int          ATM_W       = 5;
  localparam logic [5:0]  GROUP_BASE  = 6'h20;
  localparam logic [5:0]  CODE_UNUSED = 6'h30;
  localparam int          ATM_DEPTH   = 32;
  localparam int          CHAN_DEPTH  = 48;
  localparam logic [7:0]  SEL_RST     = 8'h00;
  localparam logic [5:0]  ATM_RST     = 6'h30;
  localparam logic [5:0]  CHAN_RST    = 6'h00;
  localparam int          STAT_SELOK  = 0;
  localparam int          STAT_REJECT = 1;

  // register chosen by the bus decoder
  typedef enum logic [1:0] {
    REG_NONE = 2'b00,
    REG_SEL  = 2'b01,
    REG_DATA = 2'b10,
    REG_STAT = 2'b11
  } txl_reg_e;

endpackage
`default_nettype wire

// File: txl_reg_if.sv
// interface: register strobes between the bus front end and the table core
`timescale 1ns/1ps
`default_nettype none
interface txl_reg_if;
  import txl_pkg::*;
  txl_reg_e   reg_id;   // register decoded from the bus address
  logic       wr_en;    // one-cycle write strobe
  logic [7:0] wdata;    // write data, low byte of the bus
  logic [7:0] rdata;    // read value of reg_id

  modport fe   (output reg_id, output wr_en, output wdata, input rdata);
  modport core (input reg_id, input wr_en, input wdata, output rdata);
endinterface
`default_nettype wire

// File: txl_table_mem.sv
// small flop memory with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module txl_table_mem #(
  parameter int              W       = 6,
  parameter int              DEPTH   = 32,
  parameter int              AW      = 6,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic          clk_in,
  input  wire logic          sys_rst_in,
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [W-1:0]  wr_data_in,
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [W-1:0]  rd_data_out
);

  logic [W-1:0] ent [DEPTH];

  // build check: every entry must be reachable through the address port
  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad
    $error("table depth does not fit the address width");
  end

  // ------------------------------------------------------------------
  // storage: one entry per index, reset to a known mapping
  // ------------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        ent[i] <= RST_VAL;
      end else if (wr_en_in && (wr_addr_in == AW'(i))) begin
        ent[i] <= wr_data_in;
      end
    end
  end

  // read register; holes beyond the depth read as zero
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_out <= '0;
    end else if (32'(rd_addr_in) < DEPTH) begin
      rd_data_out <= ent[rd_addr_in];
    end else begin
      rd_data_out <= '0;
    end
  end

endmodule
`default_nettype wire

// File: txl_apb_fe.sv
// APB slave front end: handshake, decode and read data register
`timescale 1ns/1ps
`default_nettype none
module txl_apb_fe (
  input  wire logic                      clk_in,
  input  wire logic                      sys_rst_in,
  input  wire logic                      psel_in,
  input  wire logic                      penable_in,
  input  wire logic                      pwrite_in,
  input  wire logic [txl_pkg::ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]               pwdata_in,
  output logic      [31:0]               prdata_out,
  output logic                           pready_out,
  output logic                           pslverr_out,
  txl_reg_if.fe                          rif
);
  import txl_pkg::*;

  logic ack_r;
  logic [31:0] prdata_r;
  wire  access = psel_in & penable_in;
  wire  done   = access & ack_r;
  wire  mapped = (rif.reg_id != REG_NONE);

  // ------------------------------------------------------------------
  // address decode: only the three aligned words answer
  // ------------------------------------------------------------------
  assign rif.reg_id = (paddr_in == SEL_ADDR)  ? REG_SEL  :
                      (paddr_in == DATA_ADDR) ? REG_DATA :
                      (paddr_in == STAT_ADDR) ? REG_STAT : REG_NONE;
  assign rif.wdata  = pwdata_in[7:0];
  assign rif.wr_en  = done & pwrite_in & mapped;

  // one wait state, so the read data register has been loaded
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= access & ~ack_r;
    end
  end

  // read data captured in the first access cycle
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prdata_r <= 32'h0;
    end else if (access && !ack_r && !pwrite_in) begin
      prdata_r <= mapped ? {24'h0, rif.rdata} : 32'h0;
    end
  end

  assign prdata_out  = prdata_r;
  assign pready_out  = ack_r;
  assign pslverr_out = ack_r & ~mapped;  // unmapped: error, no effect

endmodule
`default_nettype wire

// File: txl_xlate_sva.sv
// checker: bus handshake and readback properties of the translation table
`timescale 1ns/1ps
`default_nettype none
module txl_xlate_sva #(
  parameter int NUM_PORTS  = 32,
  parameter int NUM_GROUPS = 16
) (
  input wire logic                       clk_in,
  input wire logic                       sys_rst_in,
  input wire logic                       psel_in,
  input wire logic                       penable_in,
  input wire logic                       pwrite_in,
  input wire logic [txl_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0]                pwdata_in,
  input wire logic [31:0]                prdata_out,
  input wire logic                       pready_out,
  input wire logic                       pslverr_out
);
  import txl_pkg::*;
  logic [7:0] sel_r;
  logic       hit_sel;
  logic       hit_dat;
  logic       hit_any;
  // ----------------------------------------------------------------
  // address decode and select shadow
  // ----------------------------------------------------------------
  assign hit_sel = paddr_in == SEL_ADDR;
  assign hit_dat = paddr_in == DATA_ADDR;
  assign hit_any = hit_sel || hit_dat || paddr_in == STAT_ADDR;
  // shadow kept so a data read can be judged by its direction
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sel_r <= SEL_RST;
    end else if (pready_out && psel_in && pwrite_in && hit_sel) begin
      sel_r <= pwdata_in[7:0];
    end
  end
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_rdy_pulse; pready_out |=> !pready_out; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
  property p_rdy_wait;
    psel_in && $rose(penable_in) |-> !pready_out ##1 pready_out;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("ready timing");
  property p_rdy_acc; pready_out |-> psel_in && penable_in; endproperty
  a_rdy_acc: assert property (p_rdy_acc) else $error("ready unasked");
  property p_err_rdy; pslverr_out |-> pready_out; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("stray error");
  property p_err_map; pready_out |-> pslverr_out == !hit_any; endproperty
  a_err_map: assert property (p_err_map) else $error("decode error");
  property p_rd_hi; pready_out && !pwrite_in |-> prdata_out[31:8] == 0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits");
  property p_sel_rb; pready_out && !pwrite_in && hit_sel |->
    (prdata_out[7:0] & 8'h9f) == (sel_r & 8'h9f); endproperty
  a_sel_rb: assert property (p_sel_rb) else $error("select readback");
  property p_dat_mask; pready_out && !pwrite_in && hit_dat |->
    (sel_r[7] ? prdata_out[6:5] : prdata_out[7:6]) == 2'h0; endproperty
  a_dat_mask: assert property (p_dat_mask) else $error("ignored bits");
endmodule
bind txl_xlate_top txl_xlate_sva #(.NUM_PORTS(NUM_PORTS),
  .NUM_GROUPS(NUM_GROUPS)) txl_xlate_sva_i (.clk_in(clk_in),
  .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out));
`default_nettype wire

// File: txl_xlate_tb_top.sv
// testbench: table-driven register checks of the translation table block
`timescale 1ns/1ps
`default_nettype none
module txl_xlate_tb_top;
  import txl_pkg::*;
  typedef struct packed {
    logic [7:0] sel;
    logic       wr;
    logic [7:0] wd;
    logic [7:0] exp;
  } txl_row_s;
  // select, write flag, data written, data read back
  localparam txl_row_s ROWS [10] = '{
    '{8'h00, 1'b1, 8'h05, 8'h05}, '{8'h1f, 1'b1, 8'hf0, 8'h30},
    '{8'h7f, 1'b0, 8'h00, 8'h30}, '{8'h01, 1'b1, 8'h2f, 8'h2f},
    '{8'h01, 1'b1, 8'h31, 8'h2f}, '{8'h80, 1'b1, 8'hff, 8'h9f},
    '{8'ha0, 1'b1, 8'h7e, 8'h1e}, '{8'hc0, 1'b0, 8'h00, 8'h9f},
    '{8'h00, 1'b0, 8'h00, 8'h05}, '{8'hb0, 1'b1, 8'h81, 8'h00}};
  logic        clk_in;
  logic        sys_rst_in;
  logic        psel_in;
  logic        penable_in;
  logic        pwrite_in;
  logic [15:0] paddr_in;
  logic [31:0] pwdata_in;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic [31:0] rd;
  logic        er;
  int          failures;
  int          compares;
  txl_xlate_top txl_xlate_top_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ready, read data and error are all taken at the rising edge that
  // completes the transfer; the request is released only after it
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge clk_in);
    psel_in   <= 1'b1;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= {24'h0, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_in);
      if (pready_out === 1'b1) break;
    end
    if (n == 20) begin
      failures++;
      final_report();
    end
    rd = prdata_out;
    er = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    failures   = 0;
    compares   = 0;
    sys_rst_in = 1'b1;
    psel_in    = 1'b0;
    penable_in = 1'b0;
    pwrite_in  = 1'b0;
    paddr_in   = 16'h0000;
    pwdata_in  = 32'h0000_0000;
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    foreach (ROWS[i]) begin
      apb(1'b1, SEL_ADDR, ROWS[i].sel);
      if (ROWS[i].wr) apb(1'b1, DATA_ADDR, ROWS[i].wd);
      apb(1'b0, DATA_ADDR, 8'h00);
      chk(rd, {24'h0, ROWS[i].exp});
      chk({31'h0, er}, 32'h0);
    end
    apb(1'b0, SEL_ADDR, 8'h00);
    chk(rd, 32'h0000_00b0);
    // status: last data write refused, channel 0x30 absent in this build
    apb(1'b0, STAT_ADDR, 8'h00);
    chk(rd, 32'h1 << STAT_REJECT);
    // an accepted write clears the refusal; status writes are ignored
    apb(1'b1, SEL_ADDR, 8'h05);
    apb(1'b1, DATA_ADDR, 8'h21);
    apb(1'b0, DATA_ADDR, 8'h00);
    chk(rd, 32'h0000_0021);
    apb(1'b1, STAT_ADDR, 8'hff);
    chk({31'h0, er}, 32'h0);
    apb(1'b0, STAT_ADDR, 8'h00);
    chk(rd, 32'h1 << STAT_SELOK);
    // unmapped and misaligned places answer with an error
    apb(1'b1, 16'h1078, 8'h55);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, DATA_ADDR + 16'h1, 8'h00);
    chk({31'h0, er}, 32'h1);
    // second reset in mid-run restores the select and the table
    sys_rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    apb(1'b0, SEL_ADDR, 8'h00);
    chk(rd, {24'h0, SEL_RST});
    apb(1'b0, DATA_ADDR, 8'h00);
    chk(rd, {26'h0, ATM_RST});
    // channel table is back at its reset mapping too
    apb(1'b1, SEL_ADDR, 8'h80);
    apb(1'b0, DATA_ADDR, 8'h00);
    chk(rd, {24'h0, CHAN_RST[ATM_W], 2'h0, CHAN_RST[ATM_W-1:0]});
    final_report();
  end
endmodule
`default_nettype wire
